/* hdl/ccsr_top.sv */
// ccsr_top: channel setup registers behind a 2-wire slave port.
// assumes SCL/SDA come from pins (synchronised here) and that the
// converter strobes, ready levels run on REF_CLK.
`timescale 1ns/1ps
`default_nettype none

module ccsr_top
  import ccsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = ccsr_pkg::CCSR_DEV_ADDR,
  parameter bit         DUAL_INPUT  = 1'b1
) (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       CONV_START,
  input  wire logic       CAP_READY_N,
  input  wire logic       VT_READY_N,
  output logic            READY_N,
  output logic            CAPACITIVE_CHANNEL_ENABLE,
  output logic            SECOND_INPUT_SELECT,
  output logic            CAPACITIVE_DIFFERENTIAL_MODE,
  output logic            CAPACITIVE_CHOP_ENABLE,
  output logic            VOLT_TEMP_CHANNEL_ENABLE,
  output logic            VOLT_TEMP_INPUT_SELECT_HI,
  output logic            VOLT_TEMP_INPUT_SELECT_LO,
  output logic            EXTERNAL_REFERENCE_SELECT,
  output logic            VOLT_TEMP_INPUT_SHORT_TEST,
  output logic            VOLT_TEMP_CHOP_ENABLE
);
  import ccsr_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_q;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_q;
    ccsr_state_e st;
    ccsr_phase_e ph;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        rw;
    logic        ack_stage;
    logic        drive;
    logic [7:0]  ptr;
    logic [7:0]  cap_setup;
    logic [7:0]  vt_setup;
    logic [7:0]  cap_act;
    logic [7:0]  vt_act;
  } ccsr_regs_s;

  ccsr_regs_s r;
  ccsr_regs_s next_r;

  // register read decode, shared by first and later read bytes
  function automatic logic [7:0] ccsr_read(input logic [7:0] a,
                                           input logic [7:0] cap,
                                           input logic [7:0] vt);
    logic [7:0] v;
    v = 8'h00;
    if (a == CCSR_CAP_SETUP_ADDR) v = cap;
    else if (a == CCSR_VT_SETUP_ADDR) v = vt;
    return v;
  endfunction : ccsr_read

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] byte_in;

  // only second stages and their delayed copies feed edge logic
  assign scl_rise  = r.scl_s2 & ~r.scl_q;
  assign scl_fall  = ~r.scl_s2 & r.scl_q;
  assign bus_start = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
  assign bus_stop  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
  assign byte_in   = {r.sh[6:0], r.sda_s2};

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    next_r = r;
    next_r.scl_s1 = SCL_IN;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_q  = r.scl_s2;
    next_r.sda_s1 = SDA_IN;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_q  = r.sda_s2;

    if (bus_start) begin
      // repeated start keeps the pointer so reads can follow a write
      next_r.st        = CCSR_RX;
      next_r.ph        = CCSR_PH_ADDR;
      next_r.cnt       = 3'h0;
      next_r.ack_stage = 1'b0;
      next_r.drive     = 1'b0;
    end else if (bus_stop) begin
      next_r.st    = CCSR_IDLE;
      next_r.drive = 1'b0;
    end else begin
      unique case (r.st)
        CCSR_IDLE: begin
          next_r.drive = 1'b0;
        end
        CCSR_RX: begin
          if (scl_rise) begin
            next_r.sh  = byte_in;
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == CCSR_LAST_BIT) begin
              next_r.st        = CCSR_ACK;
              next_r.ack_stage = 1'b0;
              unique case (r.ph)
                CCSR_PH_ADDR: begin
                  next_r.rw = byte_in[0];
                  if (byte_in[7:1] != DEV_ADDR) next_r.st = CCSR_IDLE;
                end
                CCSR_PH_PTR: begin
                  next_r.ptr = byte_in;
                end
                default: begin
                  // full byte stored; reserved bits are the host's duty
                  if (r.ptr == CCSR_CAP_SETUP_ADDR)
                    next_r.cap_setup = byte_in;
                  else if (r.ptr == CCSR_VT_SETUP_ADDR)
                    next_r.vt_setup = byte_in;
                  next_r.ptr = r.ptr + 8'h01;
                end
              endcase
            end
          end
        end
        CCSR_ACK: begin
          if (scl_fall) begin
            if (!r.ack_stage) begin
              next_r.drive     = 1'b1;
              next_r.ack_stage = 1'b1;
            end else begin
              next_r.ack_stage = 1'b0;
              next_r.cnt       = 3'h0;
              if (r.ph == CCSR_PH_ADDR && r.rw) begin
                next_r.tx    = ccsr_read(r.ptr, r.cap_setup, r.vt_setup);
                next_r.drive = ~next_r.tx[7];
                next_r.ptr   = r.ptr + 8'h01;
                next_r.st    = CCSR_TX;
              end else begin
                next_r.drive = 1'b0;
                next_r.st    = CCSR_RX;
                next_r.ph    = (r.ph == CCSR_PH_ADDR) ? CCSR_PH_PTR
                                                      : CCSR_PH_DATA;
              end
            end
          end
        end
        CCSR_TX: begin
          if (scl_fall) begin
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == CCSR_LAST_BIT) begin
              next_r.drive     = 1'b0;
              next_r.ack_stage = 1'b0;
              next_r.st        = CCSR_TXACK;
            end else begin
              next_r.tx    = {r.tx[6:0], 1'b0};
              next_r.drive = ~r.tx[6];
            end
          end
        end
        CCSR_TXACK: begin
          if (scl_rise) begin
            // a not-acknowledge ends the read burst
            if (r.sda_s2) next_r.st = CCSR_IDLE;
            else next_r.ack_stage = 1'b1;
          end else if (scl_fall && r.ack_stage) begin
            next_r.ack_stage = 1'b0;
            next_r.cnt       = 3'h0;
            next_r.tx        = ccsr_read(r.ptr, r.cap_setup, r.vt_setup);
            next_r.drive     = ~next_r.tx[7];
            next_r.ptr       = r.ptr + 8'h01;
            next_r.st        = CCSR_TX;
          end
        end
        default: begin
          next_r.st = CCSR_IDLE;
        end
      endcase
    end

    // settings move to the converter only when a conversion starts,
    // so a write mid-conversion never disturbs the running one
    if (CONV_START) begin
      next_r.cap_act = r.cap_setup;
      next_r.vt_act  = r.vt_setup;
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r           <= '0;
      r.scl_s1    <= 1'b1;
      r.scl_s2    <= 1'b1;
      r.scl_q     <= 1'b1;
      r.sda_s1    <= 1'b1;
      r.sda_s2    <= 1'b1;
      r.sda_q     <= 1'b1;
      r.st        <= CCSR_IDLE;
      r.ph        <= CCSR_PH_ADDR;
      r.cap_setup <= CCSR_CAP_SETUP_RST;
      r.vt_setup  <= CCSR_VT_SETUP_RST;
      r.cap_act   <= CCSR_CAP_SETUP_RST;
      r.vt_act    <= CCSR_VT_SETUP_RST;
    end else begin
      r <= next_r;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = r.drive;

  assign CAPACITIVE_CHANNEL_ENABLE    = r.cap_act[CCSR_CAP_EN_BIT];
  // single-input build forces the first input whatever was written
  assign SECOND_INPUT_SELECT          =
    DUAL_INPUT & r.cap_act[CCSR_CAP_IN2_BIT];
  assign CAPACITIVE_DIFFERENTIAL_MODE =
    r.cap_act[CCSR_CAP_DIFF_BIT];
  // chop doubles the capacitive conversion time downstream
  assign CAPACITIVE_CHOP_ENABLE       = r.cap_act[CCSR_CAP_CHOP_BIT];
  assign VOLT_TEMP_CHANNEL_ENABLE     = r.vt_act[CCSR_VT_EN_BIT];
  assign VOLT_TEMP_INPUT_SELECT_HI    = r.vt_act[CCSR_VT_SEL_HI];
  assign VOLT_TEMP_INPUT_SELECT_LO    = r.vt_act[CCSR_VT_SEL_LO];
  // no interlock with the internal sensor: the host must choose well
  assign EXTERNAL_REFERENCE_SELECT    =
    r.vt_act[CCSR_VT_EXTERNAL_REFERENCE_SELECT_BIT];
  assign VOLT_TEMP_INPUT_SHORT_TEST   = r.vt_act[CCSR_VT_SHORT_BIT];
  assign VOLT_TEMP_CHOP_ENABLE        = r.vt_act[CCSR_VT_CHOP_BIT];

  // every enabled channel must be done; nothing enabled reads not-ready
  assign READY_N =
    (~r.cap_act[CCSR_CAP_EN_BIT] & ~r.vt_act[CCSR_VT_EN_BIT]) |
    (r.cap_act[CCSR_CAP_EN_BIT] & CAP_READY_N) |
    (r.vt_act[CCSR_VT_EN_BIT] & VT_READY_N);

endmodule : ccsr_top
`default_nettype wire

/* shared/ccsr_pkg.sv */
// ccsr_pkg: constants for the two channel setup registers of the
// capacitance-to-digital converter and its 2-wire register port.
// assumes one 50 MHz clock and a slow 2-wire bus sampled by that clock.
//
// Behaviour
// - capacitive enable bit 7 includes or excludes the capacitive channel
// - bit 6 selects second capacitive input; single-input parts keep it 0
// - capacitive bit 5 selects differential measurement, else single-ended
// - capacitive chop bit 0 roughly doubles capacitive conversion time
// - volt/temp enable bit 7 includes or excludes that channel
// - volt/temp bits 6..5: temp sensor, diode, supply monitor, voltage
// - bit 4 picks external reference; internal sensor needs internal (not enforced here: bit 4 passes through as written)
// - volt/temp bit 1 shorts the channel input for offset tests
// - volt/temp bit 0 enables chopping; host should set it
// - combined ready low only when every enabled channel has finished
// - registers reached via 2-wire pointer, auto-incremented per byte
`default_nettype none

package ccsr_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] CCSR_CAP_SETUP_ADDR = 8'h07;
  localparam logic [7:0] CCSR_VT_SETUP_ADDR  = 8'h08;
  localparam logic [7:0] CCSR_CAP_SETUP_RST  = 8'h00;
  localparam logic [7:0] CCSR_VT_SETUP_RST   = 8'h00;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int CCSR_CAP_EN_BIT   = 7;
  localparam int CCSR_CAP_IN2_BIT  = 6;
  localparam int CCSR_CAP_DIFF_BIT = 5;
  localparam int CCSR_CAP_CHOP_BIT = 0;
  localparam int CCSR_VT_EN_BIT    = 7;
  localparam int CCSR_VT_SEL_HI    = 6;
  localparam int CCSR_VT_SEL_LO    = 5;
  localparam int CCSR_VT_EXTERNAL_REFERENCE_SELECT_BIT = 4;
  localparam int CCSR_VT_SHORT_BIT = 1;
  localparam int CCSR_VT_CHOP_BIT  = 0;

  // volt/temp input select codes
  localparam logic [1:0] CCSR_VT_INT_TEMP  = 2'h0;
  localparam logic [1:0] CCSR_VT_EXT_DIODE = 2'h1;
  localparam logic [1:0] CCSR_VT_SUPPLY    = 2'h2;
  localparam logic [1:0] CCSR_VT_EXT_VOLT  = 2'h3;

  // ***********************************************************
  // serial port
  // ***********************************************************
  // arbitrary 7-bit bus address
  localparam logic [6:0] CCSR_DEV_ADDR    = 7'h48;
  localparam logic [2:0] CCSR_LAST_BIT    = 3'h7;

  typedef enum logic [2:0] {
    CCSR_IDLE, CCSR_RX, CCSR_ACK, CCSR_TX, CCSR_TXACK
  } ccsr_state_e;

  typedef enum logic [1:0] {
    CCSR_PH_ADDR, CCSR_PH_PTR, CCSR_PH_DATA
  } ccsr_phase_e;

endpackage : ccsr_pkg
`default_nettype wire

/* dv/ccsr_props.sv */
// ccsr_props: port checks for the channel setup block
// assumes one clock domain; bound to ccsr_top below
`timescale 1ns/1ps
`default_nettype none
module ccsr_props (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic CONV_START,
  input wire logic CAP_READY_N,
  input wire logic VT_READY_N,
  input wire logic READY_N,
  input wire logic CAPACITIVE_CHANNEL_ENABLE,
  input wire logic VOLT_TEMP_CHANNEL_ENABLE
);
  wire logic ce = CAPACITIVE_CHANNEL_ENABLE;
  wire logic ve = VOLT_TEMP_CHANNEL_ENABLE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ********
  // assertions
  // ********
  sda_zero_a: assert property (!SDA_OUT) else $error("sda out high");
  rdy_both_a:
    assert property (ce && ve |-> READY_N == (CAP_READY_N | VT_READY_N))
    else $error("combined ready");
  rdy_cap_a:
    assert property (ce && !ve |-> READY_N == CAP_READY_N)
    else $error("cap ready");
  rdy_vt_a:
    assert property (!ce && ve |-> READY_N == VT_READY_N)
    else $error("vt ready");
  rdy_none_a:
    assert property (!ce && !ve |-> READY_N) else $error("idle ready");
  cap_hold_a:
    assert property (!$past(CONV_START) |-> $stable(ce)) else $error("cap en");
  vt_hold_a:
    assert property (!$past(CONV_START) |-> $stable(ve)) else $error("vt en");
  // ack and data only move while the bus clock is low
  oe_still_a:
    assert property (SCL_IN [*4] |-> $stable(SDA_OE)) else $error("sda oe");
  cover property (ce && ve && !READY_N);
  cover property ($rose(SDA_OE));
  cover property (CONV_START ##1 ve);
endmodule : ccsr_props
bind ccsr_top ccsr_props ccsr_props_i (.REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .CONV_START(CONV_START), .CAP_READY_N(CAP_READY_N),
  .VT_READY_N(VT_READY_N), .READY_N(READY_N),
  .CAPACITIVE_CHANNEL_ENABLE(CAPACITIVE_CHANNEL_ENABLE),
  .VOLT_TEMP_CHANNEL_ENABLE(VOLT_TEMP_CHANNEL_ENABLE));
`default_nettype wire

/* dv/ccsr_host.sv */
// ccsr_host: behavioural 2-wire bus master for the setup registers
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ccsr_host (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  import ccsr_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // slow phases: the device sees the pins two clocks late
  task automatic slot(input logic b, output logic r);
    sda_low <= ~b;
    wt(5);
    scl <= 1'b1;
    wt(10);
    r = sda;
    scl <= 1'b0;
    wt(5);
  endtask : slot
  task automatic start();
    sda_low <= 1'b0;
    wt(5);
    scl <= 1'b1;
    wt(10);
    sda_low <= 1'b1;
    wt(10);
    scl <= 1'b0;
    wt(5);
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    wt(5);
    scl <= 1'b1;
    wt(10);
    sda_low <= 1'b0;
    wt(10);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(m, r);
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic r0, r1, r2;
    start();
    xfer({a, 1'b0}, 1'b1, q, r0);
    xfer(p, 1'b1, q, r1);
    xfer(d, 1'b1, q, r2);
    stop();
    ok = ~(r0 | r1 | r2);
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [15:0] q);
    logic r;
    start();
    xfer({CCSR_DEV_ADDR, 1'b0}, 1'b1, q[15:8], r);
    xfer(p, 1'b1, q[15:8], r);
    start();
    xfer({CCSR_DEV_ADDR, 1'b1}, 1'b1, q[15:8], r);
    xfer(8'hFF, 1'b0, q[15:8], r);
    xfer(8'hFF, 1'b1, q[7:0], r);
    stop();
  endtask : rd
endmodule : ccsr_host
`default_nettype wire

/* dv/tb.sv */
// tb: self-checking bench for the channel setup block
// assumes ccsr_host as bus partner and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccsr_pkg::*;
  logic ref_clk, sys_rst, conv_start, cap_rdy_n, vt_rdy_n;
  logic sda_out, sda_oe, ready_n, scl, sda_low, ok;
  logic [15:0] q;
  logic [7:0] d;
  wire logic [9:0] cfg;
  // open drain: a released line floats up to the pull-up level
  wire logic sda_wire = ~sda_low & (sda_oe ? sda_out : 1'b1);
  int error_cnt = 0;
  int checked = 0;
  ccsr_top ccsr_top_i (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CONV_START(conv_start),
    .CAP_READY_N(cap_rdy_n), .VT_READY_N(vt_rdy_n), .READY_N(ready_n),
    .CAPACITIVE_CHANNEL_ENABLE(cfg[9]), .SECOND_INPUT_SELECT(cfg[8]),
    .CAPACITIVE_DIFFERENTIAL_MODE(cfg[7]), .CAPACITIVE_CHOP_ENABLE(cfg[6]),
    .VOLT_TEMP_CHANNEL_ENABLE(cfg[5]), .VOLT_TEMP_INPUT_SELECT_HI(cfg[4]),
    .VOLT_TEMP_INPUT_SELECT_LO(cfg[3]), .EXTERNAL_REFERENCE_SELECT(cfg[2]),
    .VOLT_TEMP_INPUT_SHORT_TEST(cfg[1]), .VOLT_TEMP_CHOP_ENABLE(cfg[0]));
  ccsr_host ccsr_host_i (.clk(ref_clk), .sda(sda_wire), .scl(scl),
    .sda_low(sda_low));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // settings reach the outputs only through the start strobe
  task automatic go();
    @(posedge ref_clk);
    conv_start <= 1'b1;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : go
  task automatic rdy(input logic c, input logic v);
    @(posedge ref_clk);
    cap_rdy_n <= c;
    vt_rdy_n <= v;
    #1;
  endtask : rdy
  task automatic t_cap();
    ccsr_host_i.wr(CCSR_DEV_ADDR, CCSR_CAP_SETUP_ADDR, 8'hE1, ok);
    chk("ack", 16'h0001, ok);
    #1 chk("held cfg", 16'h0000, cfg);
    go();
    chk("cap cfg", 16'h000F, cfg[9:6]);
  endtask : t_cap
  task automatic t_vt();
    for (int c = 0; c < 4; c++) begin
      d = {1'b1, c[1:0], c != 0, 2'b00, c[0], 1'b1};
      ccsr_host_i.wr(CCSR_DEV_ADDR, CCSR_VT_SETUP_ADDR, d, ok);
      chk("vt ack", 16'h0001, ok);
      go();
      chk("vt cfg", {d[7:4], d[1:0]}, cfg[5:0]);
    end
  endtask : t_vt
  task automatic t_read();
    ccsr_host_i.rd(CCSR_CAP_SETUP_ADDR, q);
    chk("readback", 16'hE1F3, q);
    ccsr_host_i.rd(CCSR_VT_SETUP_ADDR, q);
    chk("unmapped", 16'hF300, q);
  endtask : t_read
  task automatic t_ready();
    for (int i = 0; i < 4; i++) begin
      rdy(i[1], i[0]);
      chk("ready both", i[1] | i[0], ready_n);
    end
    ccsr_host_i.wr(CCSR_DEV_ADDR, CCSR_CAP_SETUP_ADDR, 8'h00, ok);
    go();
    chk("cap off", 16'h0000, cfg[9:6]);
    for (int i = 0; i < 2; i++) begin
      rdy(i[0], ~i[0]);
      chk("ready vt", {15'h0000, !i[0]}, ready_n);
    end
    // capacitive channel alone, volt/temp parked with chop on
    ccsr_host_i.wr(CCSR_DEV_ADDR, CCSR_CAP_SETUP_ADDR, 8'hA0, ok);
    ccsr_host_i.wr(CCSR_DEV_ADDR, CCSR_VT_SETUP_ADDR, 8'h01, ok);
    go();
    chk("cap only", 16'h0014, cfg[9:5]);
    for (int i = 0; i < 2; i++) begin
      rdy(~i[0], i[0]);
      chk("ready cap", {15'h0000, !i[0]}, ready_n);
    end
  endtask : t_ready
  task automatic t_bad();
    ccsr_host_i.wr(CCSR_DEV_ADDR ^ 7'h01, CCSR_CAP_SETUP_ADDR, 8'h80, ok);
    chk("no ack", 16'h0000, ok);
    ccsr_host_i.rd(CCSR_CAP_SETUP_ADDR, q);
    chk("kept", 16'hA001, q);
  endtask : t_bad
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    $display("unexpected run length: expected end seen limit");
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    conv_start = 1'b0;
    cap_rdy_n = 1'b1;
    vt_rdy_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("reset cfg", 16'h0400, {5'h00, ready_n, cfg});
    ccsr_host_i.rd(CCSR_CAP_SETUP_ADDR, q);
    chk("reset regs", 16'h0000, q);
    t_cap();
    t_vt();
    t_read();
    t_ready();
    t_bad();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
